// [shared/plmrs_pkg.sv]
// package for the macrocell reset, preload and security block
// assumes a single 25 MHz clock and no register bus
package plmrs_pkg;
  localparam int          NUM_CELLS         = 8;
  localparam int          NUM_TERMS         = 8;
  localparam int          SIG_BYTES         = 8;
  localparam int          CLK_PERIOD_NS     = 40;
  // power-up reset interval, typical and maximum, in ns
  localparam int          PUR_TYP_NS        = 600;
  localparam int          PUR_MAX_NS        = 1000;
  // reset hold count: longest time, rounded down, at least one cycle
  localparam int          PUR_CYCLES_RAW    = PUR_MAX_NS / CLK_PERIOD_NS;
  localparam int          PUR_CYCLES        = (PUR_CYCLES_RAW < 1) ? 1 : PUR_CYCLES_RAW;
  localparam logic [5:0]  PUR_COUNT         = 6'(PUR_CYCLES);
  localparam logic [7:0]  CELL_RESET        = 8'h00;
  localparam logic [63:0] SIG_RESET         = 64'h0;
  localparam int          OE_TERM           = 7;

  typedef enum logic [1:0] {
    PLMRS_MODE_SIMPLE     = 2'b00,
    PLMRS_MODE_COMPLEX    = 2'b01,
    PLMRS_MODE_REGISTERED = 2'b10
  } plmrs_mode_t;

  typedef enum logic [1:0] {
    PLMRS_CELL_REG_OUT  = 2'b00,
    PLMRS_CELL_COMB_IO  = 2'b01,
    PLMRS_CELL_COMB_OUT = 2'b10,
    PLMRS_CELL_INPUT    = 2'b11
  } plmrs_cell_t;
endpackage

// [rtl/plmrs_sync2.sv]
// two-flop synchroniser for a bus of pin levels
// assumes inputs asynchronous to ref_clk_i
`timescale 1ns/1ps
module plmrs_sync2 #(
  parameter int          WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input  wire logic             ref_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_next;

  always_comb begin
    meta_next = async_i;
    sync_next = meta_reg;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_reg <= INIT;
      sync_reg <= INIT;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_o = sync_reg;
endmodule

// [rtl/plmrs_core.sv]
// eight-macrocell logic core with power-up clear, preload, security lock
// assumes pins arrive asynchronously; array terms come from on-chip logic
//
// Contract
// - at power-up every macrocell register is cleared low asynchronously.
// - registered outputs are inverted, so each shows high right after reset.
// - a preload path forces each register high or low individually.
// - once the security fuse is set, verify and preload are refused at once.
// - a 64-bit eight-byte user signature stays readable even when locked.
// - each macrocell is a registered output, comb I/O, comb output or input.
// - the device runs in exactly one of three device-wide modes.
// - undriven input and I/O pins read high as if weakly pulled up.
// - registered cells use the common clock and the shared low-active enable.
// - comb cells in registered mode use one term for enable, seven for sum.
`timescale 1ns/1ps
module plmrs_core
  import plmrs_pkg::*;
#(
  parameter int NCELL = plmrs_pkg::NUM_CELLS
) (
  input  wire logic                      ref_clk_i,
  input  wire logic                      rst_n_i,
  input  wire plmrs_pkg::plmrs_mode_t    mode_i,
  input  wire logic [2*NCELL-1:0]        cell_cfg_i,
  input  wire logic [NCELL*8-1:0]        terms_i,
  input  wire logic [NCELL-1:0]          io_pin_i,
  input  wire logic [NCELL-1:0]          io_drv_i,
  input  wire logic                      oe_n_pin_i,
  input  wire logic                      sec_fuse_set_i,
  input  wire logic                      preload_req_i,
  input  wire logic [NCELL-1:0]          preload_data_i,
  input  wire logic                      verify_req_i,
  input  wire logic [NCELL*8-1:0]        verify_pattern_i,
  input  wire logic                      sig_wr_i,
  input  wire logic [2:0]                sig_idx_i,
  input  wire logic [7:0]                sig_wdata_i,
  output logic [NCELL-1:0]               pin_o,
  output logic [NCELL-1:0]               pin_oe_o,
  output logic [NCELL-1:0]               array_fb_o,
  output logic [NCELL*8-1:0]             verify_data_o,
  output logic                           verify_valid_o,
  output logic                           req_refused_o,
  output logic                           secured_o,
  output logic [63:0]                    signature_o,
  output logic                           pur_busy_o
);
  import plmrs_pkg::*;

  logic [NCELL-1:0]   pin_sync;
  logic [NCELL-1:0]   drv_sync;
  logic               oe_n_sync;
  logic [NCELL-1:0]   cell_reg,    cell_next;
  logic [NCELL-1:0]   pin_reg,     pin_next;
  logic [NCELL-1:0]   oe_reg,      oe_next;
  logic [NCELL-1:0]   fb_reg,      fb_next;
  logic               lock_reg,    lock_next;
  logic [63:0]        sig_reg,     sig_next;
  logic [NCELL*8-1:0] vdata_reg,   vdata_next;
  logic               vvalid_reg,  vvalid_next;
  logic               refused_reg, refused_next;
  logic [5:0]         pur_reg,     pur_next;
  logic               busy_reg,    busy_next;
  logic               lock_now;
  logic [NCELL-1:0]   reg_d;
  logic [NCELL-1:0]   comb_val;
  logic [NCELL-1:0]   comb_oe;
  logic [NCELL-1:0]   pin_seen;

  plmrs_sync2 #(.WIDTH(2*NCELL+1), .INIT({(2*NCELL+1){1'b1}})) u_sync (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .async_i   ({io_pin_i, io_drv_i, oe_n_pin_i}),
    .sync_o    ({pin_sync, drv_sync, oe_n_sync})
  );

  // lock acts in the same cycle the fuse is set
  assign lock_now = lock_reg | sec_fuse_set_i;

  genvar g;
  generate
    for (g = 0; g < NCELL; g++) begin : g_cell
      logic [7:0] t;
      assign t = terms_i[g*8 +: 8];
      assign reg_d[g] = |t;
      // seven-term sum, term seven gates enable outside simple mode
      assign comb_val[g] = |t[OE_TERM-1:0];
      assign comb_oe[g]  = (mode_i == PLMRS_MODE_SIMPLE) ? 1'b1 : t[OE_TERM];
      // undriven pin reads high
      assign pin_seen[g] = drv_sync[g] ? pin_sync[g] : 1'b1;
    end
  endgenerate

  always_comb begin
    plmrs_cell_t ct;
    ct           = PLMRS_CELL_REG_OUT;
    cell_next    = cell_reg;
    pin_next     = pin_reg;
    oe_next      = oe_reg;
    fb_next      = fb_reg;
    lock_next    = lock_now;
    sig_next     = sig_reg;
    vdata_next   = '0;
    vvalid_next  = 1'b0;
    refused_next = 1'b0;
    pur_next     = (pur_reg != 6'h00) ? pur_reg - 6'h01 : 6'h00;
    busy_next    = (pur_next != 6'h00);
    for (int i = 0; i < NCELL; i++) begin
      ct = plmrs_cell_t'(cell_cfg_i[2*i +: 2]);
      if (mode_i == PLMRS_MODE_REGISTERED && ct == PLMRS_CELL_REG_OUT) begin
        cell_next[i] = reg_d[i];
        pin_next[i]  = ~cell_reg[i];
        oe_next[i]   = ~oe_n_sync;
        fb_next[i]   = cell_reg[i];
      end else if (ct == PLMRS_CELL_INPUT) begin
        pin_next[i]  = 1'b1;
        oe_next[i]   = 1'b0;
        fb_next[i]   = pin_seen[i];
      end else begin
        pin_next[i]  = comb_val[i];
        oe_next[i]   = comb_oe[i];
        fb_next[i]   = (ct == PLMRS_CELL_COMB_IO) ? pin_seen[i] : comb_val[i];
      end
    end
    if (preload_req_i) begin
      if (lock_now) begin
        refused_next = 1'b1;
      end else begin
        cell_next = preload_data_i;
        pin_next  = ~preload_data_i;
      end
    end
    if (verify_req_i) begin
      if (lock_now) begin
        refused_next = 1'b1;
      end else begin
        vdata_next  = verify_pattern_i;
        vvalid_next = 1'b1;
      end
    end
    if (sig_wr_i) begin
      sig_next[sig_idx_i*8 +: 8] = sig_wdata_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cell_reg    <= CELL_RESET;
      pin_reg     <= ~CELL_RESET;
      oe_reg      <= '0;
      fb_reg      <= CELL_RESET;
      lock_reg    <= 1'b0;
      sig_reg     <= SIG_RESET;
      vdata_reg   <= '0;
      vvalid_reg  <= 1'b0;
      refused_reg <= 1'b0;
      pur_reg     <= PUR_COUNT;
      busy_reg    <= 1'b1;
    end else begin
      cell_reg    <= cell_next;
      pin_reg     <= pin_next;
      oe_reg      <= oe_next;
      fb_reg      <= fb_next;
      lock_reg    <= lock_next;
      sig_reg     <= sig_next;
      vdata_reg   <= vdata_next;
      vvalid_reg  <= vvalid_next;
      refused_reg <= refused_next;
      pur_reg     <= pur_next;
      busy_reg    <= busy_next;
    end
  end

  assign pin_o          = pin_reg;
  assign pin_oe_o       = oe_reg;
  assign array_fb_o     = fb_reg;
  assign verify_data_o  = vdata_reg;
  assign verify_valid_o = vvalid_reg;
  assign req_refused_o  = refused_reg;
  assign secured_o      = lock_reg;
  assign signature_o    = sig_reg;
  // window where outside clocking must stay quiet
  assign pur_busy_o     = busy_reg;

  AST_LOCK_STICKY: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    lock_reg |=> lock_reg) else $error("lock dropped");
  AST_FUSE_LOCKS: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    sec_fuse_set_i |=> secured_o) else $error("fuse did not lock");
  AST_LOCKED_VERIFY: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (verify_req_i && lock_now) |=> (req_refused_o && !verify_valid_o))
    else $error("verify served while locked");
  AST_VERIFY_OK: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (verify_req_i && !lock_now) |=> (verify_valid_o && verify_data_o == $past(verify_pattern_i)))
    else $error("verify not served");
  AST_LOCKED_PRELOAD: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (preload_req_i && lock_now && mode_i != PLMRS_MODE_REGISTERED) |=> $stable(cell_reg))
    else $error("preload changed locked regs");
  AST_PRELOAD: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (preload_req_i && !lock_now) |=> (cell_reg == $past(preload_data_i)))
    else $error("preload not applied");
  AST_SIG_WRITE: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    sig_wr_i |=> (signature_o[$past(sig_idx_i)*8 +: 8] == $past(sig_wdata_i)))
    else $error("signature write lost");
  AST_REG_OUT_INV: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (mode_i == PLMRS_MODE_REGISTERED && cell_cfg_i[1:0] == 2'b00 && !preload_req_i)
    |=> (pin_o[0] == ~$past(cell_reg[0]))) else $error("reg output not inverted");
  AST_PUR_COUNT: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (pur_reg == PUR_COUNT) |-> (cell_reg == CELL_RESET && pin_o == ~CELL_RESET))
    else $error("registers not cleared at power-up");
  AST_PUR_ENDS: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    pur_busy_o |-> ##[1:25] !pur_busy_o) else $error("reset interval too long");

  COV_PRELOAD: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    preload_req_i && !lock_now);
  COV_LOCK_REFUSE: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    req_refused_o);
  COV_VERIFY: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) verify_valid_o);
  COV_SIG_LOCKED: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    sig_wr_i && secured_o);
  COV_PUR_DONE: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    $fell(pur_busy_o));
endmodule

// [sim/plmrs_far_end.sv]
// outside logic on the pin side: io drivers, pull-up level, shared enable pin
// assumes the bench decides when each pin is driven
`timescale 1ns/1ps
module plmrs_far_end (
  input  wire logic [7:0] drive_en_i,
  input  wire logic [7:0] drive_val_i,
  input  wire logic       oe_req_n_i,
  output logic      [7:0] io_pin_o,
  output logic      [7:0] io_drv_o,
  output logic            oe_n_pin_o
);
  // released pins float up
  always_comb begin
    for (int g = 0; g < 8; g++) begin
      io_pin_o[g] = drive_en_i[g] ? drive_val_i[g] : 1'b1;
    end
  end
  assign io_drv_o   = drive_en_i;
  assign oe_n_pin_o = oe_req_n_i;
endmodule

// [sim/plmrs_core_bench.sv]
// self-checking bench for the macrocell core
// assumes inputs change on the falling clock edge
`timescale 1ns/1ps
module plmrs_core_bench;
  import plmrs_pkg::*;
  logic        clk = 1'b0, rst_n = 1'b0, fuse = 1'b0, preq = 1'b0, vreq = 1'b0;
  logic        swr = 1'b0, oe_req = 1'b1;
  plmrs_mode_t mode = PLMRS_MODE_REGISTERED;
  logic [15:0] cfg = 16'h0000;
  logic [63:0] terms = 64'h0, vpat = 64'h0, vdata, sig;
  logic [7:0]  pdata = 8'h00, swd = 8'h00, drv_en = 8'h00, drv_val = 8'h00;
  logic [2:0]  sidx = 3'h0;
  logic [7:0]  io_pin, io_drv, pin, pin_oe, fb;
  logic        oe_n, vvalid, refused, secured, busy;
  int          failures = 0, num_checks = 0, cycles = 0;

  always #20 clk = ~clk;

  plmrs_far_end i_plmrs_far_end (.drive_en_i(drv_en), .drive_val_i(drv_val),
    .oe_req_n_i(oe_req), .io_pin_o(io_pin), .io_drv_o(io_drv), .oe_n_pin_o(oe_n));

  plmrs_core i_plmrs_core (.ref_clk_i(clk), .rst_n_i(rst_n), .mode_i(mode), .cell_cfg_i(cfg),
    .terms_i(terms), .io_pin_i(io_pin), .io_drv_i(io_drv), .oe_n_pin_i(oe_n),
    .sec_fuse_set_i(fuse), .preload_req_i(preq), .preload_data_i(pdata),
    .verify_req_i(vreq), .verify_pattern_i(vpat), .sig_wr_i(swr), .sig_idx_i(sidx),
    .sig_wdata_i(swd), .pin_o(pin), .pin_oe_o(pin_oe), .array_fb_o(fb),
    .verify_data_o(vdata), .verify_valid_o(vvalid), .req_refused_o(refused),
    .secured_o(secured), .signature_o(sig), .pur_busy_o(busy));

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic final_report();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask

  // preload held for three edges, pins checked while it stands
  task automatic preload(input logic [7:0] d, input logic [7:0] exp, input logic exp_ref);
    preq  = 1'b1;
    pdata = d;
    step(3);
    chk("pin", {56'h0, exp}, {56'h0, pin});
    chk("refused", {63'h0, exp_ref}, {63'h0, refused});
    preq = 1'b0;
    step(1);
  endtask

  task automatic verify(input logic [63:0] pat, input logic ok);
    vreq = 1'b1;
    vpat = pat;
    step(1);
    vreq = 1'b0;
    chk("valid", {63'h0, ok}, {63'h0, vvalid});
    chk("refused", {63'h0, !ok}, {63'h0, refused});
    if (ok)
      chk("vdata", pat, vdata);
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 1000) begin
      failures++;
      final_report();
    end
  end

  initial begin
    step(11);
    chk("pin", 64'hff, {56'h0, pin});
    chk("oe", 64'h0, {56'h0, pin_oe});
    step(1);
    rst_n = 1'b1;
    step(24);
    chk("busy", 64'h1, {63'h0, busy});
    step(2);
    chk("busy", 64'h0, {63'h0, busy});
    oe_req = 1'b0;
    step(5);
    chk("oe", 64'hff, {56'h0, pin_oe});
    oe_req = 1'b1;
    step(5);
    chk("oe", 64'h0, {56'h0, pin_oe});
    terms = 64'h0000_0101_0101_0000;
    step(3);
    chk("pin", 64'hc3, {56'h0, pin});
    terms = 64'h8000_0000_0000_0080;
    step(3);
    chk("pin", 64'h7e, {56'h0, pin});
    terms = 64'h0;
    preload(8'h5a, 8'ha5, 1'b0);
    preload(8'ha5, 8'h5a, 1'b0);
    verify(64'h0123_4567_89ab_cdef, 1'b1);
    swr = 1'b1;
    for (int k = 0; k < 8; k++) begin
      sidx = 3'(k);
      swd  = 8'h10 + 8'(k);
      step(1);
    end
    swr = 1'b0;
    step(1);
    chk("sig", 64'h1716_1514_1312_1110, sig);
    fuse = 1'b1;
    preload(8'h0f, 8'hff, 1'b1);
    fuse = 1'b0;
    chk("secured", 64'h1, {63'h0, secured});
    verify(64'hfedc_ba98_7654_3210, 1'b0);
    swr  = 1'b1;
    sidx = 3'h0;
    swd  = 8'hee;
    step(1);
    swr = 1'b0;
    step(1);
    chk("sig", 64'h1716_1514_1312_11ee, sig);
    cfg   = 16'h5555;
    terms = 64'h0000_0000_0000_0180;
    step(4);
    chk("oe", 64'h01, {56'h0, pin_oe});
    mode = PLMRS_MODE_SIMPLE;
    cfg  = 16'haaaa;
    step(4);
    chk("oe", 64'hff, {56'h0, pin_oe});
    preload(8'h0f, 8'h02, 1'b1);
    mode    = PLMRS_MODE_COMPLEX;
    cfg     = 16'hffff;
    drv_en  = 8'h0f;
    drv_val = 8'h05;
    step(4);
    chk("oe", 64'h0, {56'h0, pin_oe});
    chk("pin", 64'hff, {56'h0, pin});
    chk("fb", 64'hf5, {56'h0, fb});
    final_report();
  end
endmodule
